// [rtl/dmot_consts.svh]
// constants for the data-move opcode timing block
// Summary of operation
// - in the first state of a halt after a read, outside powerdown or idle, the shared address/data lines float.
// - in the first state of a halt after anything else, those lines stay driven with junk.
// - during a halt all other control lines are inactive and the address is meaningless.
// - in powerdown or idle every address output is driven to zero.
// - the wide-bus build has a six-byte prefetch queue filled ahead of execution.
// - the narrow-bus build has a four-byte prefetch queue.
// - memory-touching opcodes may take one or two clocks over minimum from the handshake.
// - jump and call counts include fetching the next opcode at the target.
// - load segment register takes 2 clocks from a register, 9 or 13 from memory.
// - store segment register takes 2 clocks to a register, 11 or 15 to memory.
// - far-pointer load to data segment takes memory only and 18 or 26 clocks.
// - far-pointer load to extra segment takes memory only and 18 or 26 clocks.
// - flags-to-acc-high is one byte and takes 2 clocks on both builds.
// - acc-high-to-flags is one byte and takes 3 clocks on both builds.
// - table byte translate takes 11 clocks wide and 15 clocks narrow.
// - effective offset load takes 6 clocks and no memory access.
`ifndef DMOT_CONSTS_SVH
`define DMOT_CONSTS_SVH

`define DMOT_QDEPTH_WIDE 6
`define DMOT_QDEPTH_NARROW 4

`define DMOT_OP_SEG_LOAD 8'h8e
`define DMOT_OP_SEG_STORE 8'h8c
`define DMOT_OP_PTR_DS 8'hc5
`define DMOT_OP_PTR_ES 8'hc4
`define DMOT_OP_FLAGS_TO_AH 8'h9f
`define DMOT_OP_AH_TO_FLAGS 8'h9e
`define DMOT_OP_XLATE 8'hd7
`define DMOT_OP_EA_LOAD 8'h8d
`define DMOT_OP_CALL_NEAR 8'he8
`define DMOT_OP_JMP_NEAR 8'he9
`define DMOT_OP_JMP_SHORT 8'heb

`define DMOT_MOD_REG 2'h3
`define DMOT_MOD_HI 7
`define DMOT_MOD_LO 6

`define DMOT_CLK_REG_FORM 8'h02
`define DMOT_CLK_SEG_LOAD_W 8'h09
`define DMOT_CLK_SEG_LOAD_N 8'h0d
`define DMOT_CLK_SEG_STORE_W 8'h0b
`define DMOT_CLK_SEG_STORE_N 8'h0f
`define DMOT_CLK_PTR_W 8'h12
`define DMOT_CLK_PTR_N 8'h1a
`define DMOT_CLK_FLAGS_TO_AH 8'h02
`define DMOT_CLK_AH_TO_FLAGS 8'h03
`define DMOT_CLK_XLATE_W 8'h0b
`define DMOT_CLK_XLATE_N 8'h0f
`define DMOT_CLK_EA_LOAD 8'h06
`define DMOT_CLK_JUMP 8'h0e
`define DMOT_HS_MAX 2'h2

`define DMOT_AD_IDLE 16'h0000
`define DMOT_ADDR_IDLE 4'h0

`endif

// [rtl/dmot_pkg.sv]
// types shared by the data-move opcode timing block
package dmot_pkg;

    // bus pins as seen from the core side and at the pins
    typedef struct packed {
        logic [15:0] ad;     // multiplexed address/data
        logic ad_oe_n;       // low while ad is driven
        logic [3:0] addr;    // upper address lines
        logic rd_n;          // read strobe
        logic wr_n;          // write strobe
        logic ale;           // address latch enable
    } dmot_bus_t;

    // decoder sequencing
    typedef enum logic [3:0] {
        DMOT_S_OPCODE = 4'h1,
        DMOT_S_MODRM = 4'h2,
        DMOT_S_EXEC = 4'h4,
        DMOT_S_TARGET = 4'h8
    } dmot_exec_state_t;

    // halt cycle sequencing on the pins
    typedef enum logic [2:0] {
        DMOT_H_RUN = 3'h1,
        DMOT_H_FIRST = 3'h2,
        DMOT_H_HALTED = 3'h4
    } dmot_halt_state_t;

    // one finished instruction
    typedef struct packed {
        logic [7:0] opcode;  // opcode that retired
        logic [7:0] clocks;  // clocks it took
        logic mem;           // it touched memory
    } dmot_retire_t;

endpackage

// [rtl/dmot_prefetch_queue.sv]
// byte-wide prefetch queue in flip-flops
`timescale 1ns/1ps
`include "dmot_consts.svh"
module dmot_prefetch_queue #(
    parameter int DEPTH = `DMOT_QDEPTH_WIDE
) (
    input wire logic core_clk, // block clock
    input wire logic reset, // synchronous, active high
    input wire logic clk_en, // freezes state when low
    input wire logic flush, // drop everything held
    input wire logic [7:0] in_byte, // byte from the bus side
    input wire logic in_valid, // in_byte is offered
    output logic in_ready, // room for a byte
    output logic [7:0] out_byte, // oldest byte
    output logic out_valid, // a byte is held
    input wire logic out_ready, // consumer takes the byte
    output logic [$clog2(DEPTH+1)-1:0] level // bytes held
);
    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] mem_d [DEPTH];
    logic [PW-1:0] rd_q, rd_d, wr_q, wr_d;
    logic [LW-1:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != LW'(DEPTH)) && !flush;
    assign out_valid = (cnt_q != '0);
    assign out_byte = mem_q[rd_q];
    assign level = cnt_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready && !flush;

    // pointer wrap by compare, depth need not be a power of two
    always_comb begin
        mem_d = mem_q;
        rd_d = rd_q;
        wr_d = wr_q;
        cnt_d = cnt_q;
        if (flush) begin
            rd_d = '0;
            wr_d = '0;
            cnt_d = '0;
        end else begin
            if (push) begin
                mem_d[wr_q] = in_byte;
                wr_d = (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_d = (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_d = cnt_q + LW'(push) - LW'(pop);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_q <= '0;
            wr_q <= '0;
            cnt_q <= '0;
            mem_q <= '{default: 8'h00};
        end else if (clk_en) begin
            rd_q <= rd_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end
endmodule // dmot_prefetch_queue

// [rtl/dmot_core.sv]
// data-move opcode decoder, clock counter and halt/low-power pin control
`timescale 1ns/1ps
`include "dmot_consts.svh"
module dmot_core #(
    parameter bit WIDE_BUS = 1'b1, // 1: 16-bit bus build, 0: 8-bit
    parameter logic [7:0] JUMP_CLOCKS = `DMOT_CLK_JUMP // jump minimum
) (
    input wire logic core_clk, // 40 MHz block clock
    input wire logic reset, // synchronous, active high
    input wire logic clk_en, // freezes all state when low
    input wire logic [7:0] fetch_byte, // prefetched code byte
    input wire logic fetch_valid, // fetch_byte offered
    output logic fetch_ready, // queue has room
    input wire logic [1:0] hs_extra, // handshake slip, 0..2 clocks
    output logic retire_valid, // one-cycle pulse per instruction
    output dmot_pkg::dmot_retire_t retire, // retired opcode and clocks
    output logic illegal, // one-cycle pulse, unsupported form
    output logic target_flush, // pulse, queue emptied for a jump
    input wire logic halt_req, // core asks for a halt cycle
    input wire logic low_power, // powerdown or idle active
    input wire dmot_pkg::dmot_bus_t core_bus, // normal bus drive
    output dmot_pkg::dmot_bus_t pin_bus, // registered pin drive
    output logic [3:0] queue_level // bytes waiting in the queue
);
    import dmot_pkg::*;

    localparam int QDEPTH = WIDE_BUS ? `DMOT_QDEPTH_WIDE
                                     : `DMOT_QDEPTH_NARROW;
    localparam int LW = $clog2(QDEPTH+1);

    logic [7:0] q_byte;
    logic q_valid, q_pop, q_flush;
    logic [LW-1:0] q_level;

    // the bus front end fills this ahead of the decoder
    dmot_prefetch_queue #(.DEPTH(QDEPTH)) u_queue (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .flush(q_flush),
        .in_byte(fetch_byte),
        .in_valid(fetch_valid),
        .in_ready(fetch_ready),
        .out_byte(q_byte),
        .out_valid(q_valid),
        .out_ready(q_pop),
        .level(q_level)
    );
    assign queue_level = 4'(q_level);

    // class of the opcode at the head of the queue
    function automatic logic op_needs_modrm(input logic [7:0] op);
        return op == `DMOT_OP_SEG_LOAD || op == `DMOT_OP_SEG_STORE ||
               op == `DMOT_OP_PTR_DS || op == `DMOT_OP_PTR_ES ||
               op == `DMOT_OP_EA_LOAD;
    endfunction

    function automatic logic op_is_jump(input logic [7:0] op);
        return op == `DMOT_OP_CALL_NEAR || op == `DMOT_OP_JMP_NEAR ||
               op == `DMOT_OP_JMP_SHORT;
    endfunction

    function automatic logic op_single(input logic [7:0] op);
        return op == `DMOT_OP_FLAGS_TO_AH ||
               op == `DMOT_OP_AH_TO_FLAGS ||
               op == `DMOT_OP_XLATE;
    endfunction

    // minimum clocks, queue primed, no waits, aligned words
    function automatic logic [7:0] op_clocks(input logic [7:0] op,
                                             input logic mem);
        logic [7:0] c;
        c = `DMOT_CLK_REG_FORM;
        case (op)
            `DMOT_OP_SEG_LOAD: begin
                if (mem) c = WIDE_BUS ? `DMOT_CLK_SEG_LOAD_W
                                      : `DMOT_CLK_SEG_LOAD_N;
            end
            `DMOT_OP_SEG_STORE: begin
                if (mem) c = WIDE_BUS ? `DMOT_CLK_SEG_STORE_W
                                      : `DMOT_CLK_SEG_STORE_N;
            end
            `DMOT_OP_PTR_DS, `DMOT_OP_PTR_ES: begin
                c = WIDE_BUS ? `DMOT_CLK_PTR_W : `DMOT_CLK_PTR_N;
            end
            `DMOT_OP_FLAGS_TO_AH: c = `DMOT_CLK_FLAGS_TO_AH;
            `DMOT_OP_AH_TO_FLAGS: c = `DMOT_CLK_AH_TO_FLAGS;
            `DMOT_OP_XLATE: begin
                c = WIDE_BUS ? `DMOT_CLK_XLATE_W : `DMOT_CLK_XLATE_N;
            end
            `DMOT_OP_EA_LOAD: c = `DMOT_CLK_EA_LOAD;
            default: c = JUMP_CLOCKS;
        endcase
        return c;
    endfunction

    dmot_exec_state_t st_q, st_d;
    logic [7:0] op_q, op_d, elapsed_q, elapsed_d, total_q, total_d;
    logic mem_q, mem_d, jump_q, jump_d;
    logic retire_q, retire_d, illegal_q, illegal_d, flush_q, flush_d;
    dmot_retire_t ret_q, ret_d;
    logic [7:0] tot_now;
    logic mem_now;
    logic [1:0] slip;

    // slip beyond two clocks cannot happen, clamp it
    assign slip = (hs_extra > `DMOT_HS_MAX) ? `DMOT_HS_MAX : hs_extra;
    assign q_flush = flush_q;

    // decoder next state; elapsed counts clocks since opcode taken
    always_comb begin
        st_d = st_q;
        op_d = op_q;
        elapsed_d = elapsed_q + 8'h01;
        total_d = total_q;
        mem_d = mem_q;
        jump_d = jump_q;
        retire_d = 1'b0;
        illegal_d = 1'b0;
        flush_d = 1'b0;
        ret_d = ret_q;
        q_pop = 1'b0;
        mem_now = 1'b0;
        tot_now = 8'h00;
        unique case (st_q)
            DMOT_S_OPCODE: begin
                elapsed_d = 8'h01;
                if (q_valid) begin
                    q_pop = 1'b1;
                    op_d = q_byte;
                    mem_d = (q_byte == `DMOT_OP_XLATE);
                    jump_d = op_is_jump(q_byte);
                    tot_now = op_clocks(q_byte, mem_d) +
                              (mem_d ? 8'(slip) : 8'h00);
                    total_d = tot_now;
                    if (op_needs_modrm(q_byte)) begin
                        st_d = DMOT_S_MODRM;
                    end else if (op_single(q_byte) || jump_d) begin
                        st_d = DMOT_S_EXEC;
                    end else begin
                        illegal_d = 1'b1;
                    end
                end
            end
            DMOT_S_MODRM: begin
                if (q_valid) begin
                    q_pop = 1'b1;
                    mem_now = (q_byte[`DMOT_MOD_HI:`DMOT_MOD_LO]
                               != `DMOT_MOD_REG) &&
                              (op_q != `DMOT_OP_EA_LOAD);
                    mem_d = mem_now;
                    tot_now = op_clocks(op_q, mem_now) +
                              (mem_now ? 8'(slip) : 8'h00);
                    total_d = tot_now;
                    if ((op_q == `DMOT_OP_PTR_DS ||
                         op_q == `DMOT_OP_PTR_ES) &&
                        q_byte[`DMOT_MOD_HI:`DMOT_MOD_LO]
                        == `DMOT_MOD_REG) begin
                        illegal_d = 1'b1;
                        st_d = DMOT_S_OPCODE;
                    end else if (elapsed_q >= tot_now - 8'h01) begin
                        retire_d = 1'b1;
                        ret_d = '{opcode: op_q, clocks: elapsed_q + 8'h01,
                                  mem: mem_now};
                        st_d = DMOT_S_OPCODE;
                    end else begin
                        st_d = DMOT_S_EXEC;
                    end
                end
            end
            DMOT_S_EXEC: begin
                if (elapsed_q >= total_q - 8'h01) begin
                    if (jump_q) begin
                        flush_d = 1'b1;
                        st_d = DMOT_S_TARGET;
                    end else begin
                        retire_d = 1'b1;
                        ret_d = '{opcode: op_q, clocks: elapsed_q + 8'h01,
                                  mem: mem_q};
                        st_d = DMOT_S_OPCODE;
                    end
                end
            end
            DMOT_S_TARGET: begin
                // done only once the target opcode sits in the queue
                if (q_valid && !flush_q) begin
                    retire_d = 1'b1;
                    ret_d = '{opcode: op_q, clocks: elapsed_q,
                              mem: mem_q};
                    st_d = DMOT_S_OPCODE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= DMOT_S_OPCODE;
            op_q <= 8'h00;
            elapsed_q <= 8'h00;
            total_q <= 8'h00;
            mem_q <= 1'b0;
            jump_q <= 1'b0;
            retire_q <= 1'b0;
            illegal_q <= 1'b0;
            flush_q <= 1'b0;
            ret_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
            op_q <= op_d;
            elapsed_q <= elapsed_d;
            total_q <= total_d;
            mem_q <= mem_d;
            jump_q <= jump_d;
            retire_q <= retire_d;
            illegal_q <= illegal_d;
            flush_q <= flush_d;
            ret_q <= ret_d;
        end
    end
    assign retire_valid = retire_q;
    assign retire = ret_q;
    assign illegal = illegal_q;
    assign target_flush = flush_q;

    dmot_halt_state_t hs_q, hs_d;
    logic last_read_q, last_read_d;
    dmot_bus_t pin_q, pin_d;

    // halt and low-power override of the pins, registered on the way out
    always_comb begin
        hs_d = hs_q;
        last_read_d = last_read_q;
        pin_d = core_bus;
        if (hs_q == DMOT_H_RUN && !core_bus.rd_n) last_read_d = 1'b1;
        if (hs_q == DMOT_H_RUN && !core_bus.wr_n) last_read_d = 1'b0;
        unique case (hs_q)
            DMOT_H_RUN: if (halt_req) hs_d = DMOT_H_FIRST;
            DMOT_H_FIRST: hs_d = halt_req ? DMOT_H_HALTED : DMOT_H_RUN;
            DMOT_H_HALTED: if (!halt_req) hs_d = DMOT_H_RUN;
        endcase
        if (hs_d != DMOT_H_RUN) begin
            pin_d.rd_n = 1'b1;
            pin_d.wr_n = 1'b1;
            pin_d.ale = 1'b0;
            pin_d.ad = pin_q.ad; // stale, so carries no valid data
            pin_d.addr = pin_q.addr;
            // float after a read so the memory can get off the bus
            pin_d.ad_oe_n = (hs_d == DMOT_H_FIRST) ? last_read_d
                                                   : 1'b1;
        end
        if (low_power) begin
            pin_d.ad = `DMOT_AD_IDLE;
            pin_d.addr = `DMOT_ADDR_IDLE;
            pin_d.ad_oe_n = 1'b0;
            pin_d.rd_n = 1'b1;
            pin_d.wr_n = 1'b1;
            pin_d.ale = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            hs_q <= DMOT_H_RUN;
            last_read_q <= 1'b0;
            pin_q <= '{ad: 16'h0000, ad_oe_n: 1'b1, addr: 4'h0,
                       rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0};
        end else if (clk_en) begin
            hs_q <= hs_d;
            last_read_q <= last_read_d;
            pin_q <= pin_d;
        end
    end
    assign pin_bus = pin_q;

    // checks
    logic take_op;
    assign take_op = clk_en && st_q == DMOT_S_OPCODE && q_valid;

    property p_float_after_read;
        @(posedge core_clk) disable iff (reset)
        clk_en && hs_q == DMOT_H_RUN && halt_req && last_read_d && !low_power
        |=> pin_bus.ad_oe_n;
    endproperty
    a_float_after_read: assert property (p_float_after_read)
        else $error("ad lines driven in first halt state after read");

    property p_drive_no_read;
        @(posedge core_clk) disable iff (reset)
        clk_en && hs_q == DMOT_H_RUN && halt_req && !last_read_d
        |=> !pin_bus.ad_oe_n;
    endproperty
    a_drive_no_read: assert property (p_drive_no_read)
        else $error("ad lines floated in first halt state without read");

    property p_ctrl_idle;
        @(posedge core_clk) disable iff (reset)
        clk_en && hs_d != DMOT_H_RUN
        |=> pin_bus.rd_n && pin_bus.wr_n && !pin_bus.ale;
    endproperty
    a_ctrl_idle: assert property (p_ctrl_idle)
        else $error("control line active during halt");

    property p_low_power_zero;
        @(posedge core_clk) disable iff (reset)
        clk_en && low_power |=> pin_bus.addr == 4'h0 && pin_bus.ad == 16'h0;
    endproperty
    a_low_power_zero: assert property (p_low_power_zero)
        else $error("address not zero in low-power mode");

    property p_queue_depth;
        @(posedge core_clk) disable iff (reset)
        q_level == LW'(QDEPTH) |-> !fetch_ready;
    endproperty
    a_queue_depth: assert property (p_queue_depth)
        else $error("queue accepts a byte beyond its depth");

    property p_flags_to_ah;
        @(posedge core_clk) disable iff (reset)
        take_op && q_byte == 8'h9f ##1 clk_en ##1 clk_en
        |-> retire_valid && retire.clocks == 8'h02;
    endproperty
    a_flags_to_ah: assert property (p_flags_to_ah)
        else $error("flags-to-acc-high did not retire in 2 clocks");

    property p_ah_to_flags;
        @(posedge core_clk) disable iff (reset)
        take_op && q_byte == 8'h9e ##1 clk_en [*3]
        |-> retire_valid && retire.clocks == 8'h03;
    endproperty
    a_ah_to_flags: assert property (p_ah_to_flags)
        else $error("acc-high-to-flags did not retire in 3 clocks");

    property p_ptr_reg_illegal;
        @(posedge core_clk) disable iff (reset)
        clk_en && st_q == DMOT_S_MODRM && q_valid &&
        (op_q == 8'hc5 || op_q == 8'hc4) && q_byte[7:6] == 2'h3
        |=> illegal && !retire_valid;
    endproperty
    a_ptr_reg_illegal: assert property (p_ptr_reg_illegal)
        else $error("far-pointer load with register form not refused");

    property p_ea_no_mem;
        @(posedge core_clk) disable iff (reset)
        retire_valid && retire.opcode == 8'h8d
        |-> !retire.mem && retire.clocks == 8'h06;
    endproperty
    a_ea_no_mem: assert property (p_ea_no_mem)
        else $error("effective offset load wrong count or touched memory");

    property p_min_count;
        @(posedge core_clk) disable iff (reset)
        retire_valid && retire.opcode == 8'h8e && retire.mem
        |-> retire.clocks >= (WIDE_BUS ? 8'h09 : 8'h0d) &&
            retire.clocks <= (WIDE_BUS ? 8'h0b : 8'h0f);
    endproperty
    a_min_count: assert property (p_min_count)
        else $error("segment load from memory count out of range");
endmodule // dmot_core

// [dv/dmot_code_src.sv]
// code byte source standing in for the bus front end
`timescale 1ns/1ps
module dmot_code_src (
    input wire logic core_clk, // block clock
    input wire logic reset, // synchronous, active high
    input wire logic stall, // hold back new offers
    input wire logic fetch_ready, // queue has room
    output logic [7:0] fetch_byte, // offered byte
    output logic fetch_valid // byte offered
);
    logic [7:0] pend[$];
    // bench hands bytes over in program order
    task automatic put(input logic [7:0] b);
        pend.push_back(b);
    endtask
    // offer held until taken; idle lines toggle so stale bytes never pass
    always @(posedge core_clk) begin
        if (reset) begin
            fetch_valid <= 1'b0;
            fetch_byte <= 8'h00;
        end else if (!fetch_valid || fetch_ready) begin
            if (fetch_valid) void'(pend.pop_front());
            if (!stall && pend.size() != 0) begin
                fetch_valid <= 1'b1;
                fetch_byte <= pend[0];
            end else begin
                fetch_valid <= 1'b0;
                fetch_byte <= ~fetch_byte;
            end
        end
    end
endmodule // dmot_code_src

// [dv/data_move_opcode_timing_tb_top.sv]
// self-checking bench for the data-move opcode timing core
`timescale 1ns/1ps
module data_move_opcode_timing_tb_top;
    import dmot_pkg::*;
    logic core_clk = 1'b0, reset = 1'b1, halt_req = 1'b0, low_power = 1'b0;
    logic stall = 1'b0, fetch_valid, fetch_ready, retire_valid, illegal;
    logic [1:0] hs_extra = 2'h0;
    logic [7:0] fetch_byte, lfsr = 8'h25;
    logic [3:0] queue_level, max_level;
    dmot_bus_t core_bus = '{16'h0, 1'b1, 4'h0, 1'b1, 1'b1, 1'b0};
    dmot_bus_t pin_bus;
    dmot_retire_t retire;
    dmot_retire_t exp_q[$];
    dmot_retire_t note;
    logic target_flush;
    logic [3:0] pin_ctl;
    int bad_count = 0, checks_done = 0;
    // {opcode, modrm, minimum clocks} for the wide build
    localparam logic [23:0] TBL [10] = '{24'h8ec002, 24'h8e0609,
        24'h8cc002, 24'h8c060b, 24'hc50612, 24'hc40612, 24'h9f0002,
        24'h9e0003, 24'hd7000b, 24'h8d0606};

    dmot_core #(.WIDE_BUS(1'b1)) dut_u (.core_clk(core_clk), .reset(reset),
        .clk_en(1'b1), .fetch_byte(fetch_byte), .fetch_valid(fetch_valid),
        .fetch_ready(fetch_ready), .hs_extra(hs_extra),
        .retire_valid(retire_valid), .retire(retire), .illegal(illegal),
        .target_flush(target_flush), .halt_req(halt_req),
        .low_power(low_power), .core_bus(core_bus), .pin_bus(pin_bus),
        .queue_level(queue_level));
    // strobes and enable of the pins, for the halt checks
    assign pin_ctl = {pin_bus.ad_oe_n, pin_bus.rd_n, pin_bus.wr_n, pin_bus.ale};
    dmot_code_src src_u (.core_clk(core_clk), .reset(reset), .stall(stall),
        .fetch_ready(fetch_ready), .fetch_byte(fetch_byte),
        .fetch_valid(fetch_valid));

    always #12.5 core_clk = ~core_clk;

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic cmp_ret(input dmot_retire_t got, input dmot_retire_t exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_val(input logic [19:0] got, input logic [19:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // note the expected retire, then hand the bytes to the source
    task automatic send(input logic [23:0] e);
        logic [7:0] op;
        logic has_m, mem;
        logic [7:0] slip;
        op = e[23:16];
        has_m = !(op inside {8'h9f, 8'h9e, 8'hd7});
        mem = op == 8'hd7 || (has_m && e[15:14] != 2'h3 && op != 8'h8d);
        slip = (hs_extra == 2'h3) ? 8'h02 : 8'(hs_extra);
        exp_q.push_back('{op, e[7:0] + (mem ? slip : 8'h00), mem});
        src_u.put(op);
        if (has_m) src_u.put(e[15:8]);
    endtask
    // bounded wait until every noted result has shown up
    task automatic drain;
        for (int n = 0; n < 300 && exp_q.size() != 0; n++) @(posedge core_clk);
        cmp_val(20'(exp_q.size()), 20'h0);
    endtask
    // halt after a read floats ad, after a write keeps driving it
    task automatic halt_case(input logic rd);
        @(posedge core_clk);
        core_bus <= '{{lfsr, lfsr}, 1'b0, 4'h3, !rd, rd, 1'b1};
        @(posedge core_clk);
        halt_req <= 1'b1;
        @(posedge core_clk);
        #1 cmp_val(20'(pin_ctl), {16'h0, rd, 3'b110});
        @(posedge core_clk);
        #1 cmp_val(20'(pin_ctl), 20'he);
        @(posedge core_clk);
        halt_req <= 1'b0;
    endtask

    // result watcher: oldest note against each retire or illegal pulse
    always @(posedge core_clk) begin
        if (!reset) begin
            if (retire_valid === 1'b1)
                cmp_ret(retire, exp_q.size() ? exp_q.pop_front() : '1);
            if (illegal === 1'b1) begin
                note = exp_q.size() ? exp_q.pop_front() : '0;
                cmp_val(20'(note.clocks), 20'hff);
            end
            if (queue_level > max_level) max_level <= queue_level;
        end
    end

    // watchdog sized well past the expected run
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        close_out();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        // every listed form, random handshake slip on memory forms
        for (int i = 0; i < 10; i++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge core_clk);
            hs_extra <= lfsr[1:0];
            @(posedge core_clk);
            send(TBL[i]);
            drain();
        end
        $display("done: opcode timing");
        // unsupported opcode, then far pointer load with register form
        exp_q.push_back('{8'h00, 8'hff, 1'b0});
        exp_q.push_back('{8'hc5, 8'hff, 1'b0});
        src_u.put(8'h00);
        src_u.put(8'hc5);
        src_u.put(8'hc0);
        drain();
        $display("done: refused forms");
        // long translate lets one-byte opcodes pile up until the queue is full
        stall <= 1'b1;
        max_level <= 4'h0;
        send(TBL[8]);
        for (int i = 0; i < 8; i++) send(TBL[6 + i % 2]);
        @(posedge core_clk);
        stall <= 1'b0;
        drain();
        cmp_val(20'(max_level), 20'h6);
        $display("done: prefetch depth");
        // jump: 14 clocks to the flush, target offered late lands 3 later
        exp_q.push_back('{8'he9, 8'h11, 1'b0});
        exp_q.push_back('{8'h9f, 8'h02, 1'b0});
        src_u.put(8'he9);
        @(posedge core_clk iff target_flush === 1'b1);
        #1 src_u.put(8'h9f);
        drain();
        $display("done: jump");
        halt_case(1'b1);
        halt_case(1'b0);
        $display("done: halt cycles");
        // low power forces every address output low
        @(posedge core_clk);
        lfsr = lfsr_next(lfsr);
        core_bus <= '{{lfsr, ~lfsr}, 1'b0, 4'hf, 1'b1, 1'b1, 1'b0};
        low_power <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1 cmp_val({pin_bus.ad, pin_bus.addr}, 20'h0);
        @(posedge core_clk);
        low_power <= 1'b0;
        $display("done: low power");
        close_out();
    end
endmodule // data_move_opcode_timing_tb_top
